/* File: rtl/rxia_top.sv */
// rx integration period registers and external ram access sequencer
// ----------------------------------------------------------------
// Notes on behaviour
// [R1] code k gives 2^(8+k) cycle integration
// [R2] group n in 3:0, n+4 in 11:8
// [R3] software never writes code 1111
// [R4] suggested codes for e1, t1, t1 isdn
// [R5] software writes zeros to bits 7:4
// [R6] integration bits 15:12 read zero
// [R7] control write clears ready; done sets it
// [R8] toggle bit flips on each ready rise
// [R9] bit 5 picks transfer direction
// [R10] bit 1 set blocks all ram activity
// [R11] bits 1:0 = 00 initialise ram
// [R12] bits 1:0 = 01 one read or write
// [R13] software keeps control bit 2 zero
// [R14] control resets ready set, rest zero
// [R15] 8-bit data register, upper byte zero
// [R16] software waits for ready before next request
// [R17] new code applies at next period start
// ----------------------------------------------------------------
`timescale 1ns/10ps
module rxia_top (
	input wire logic clk,
	input wire logic nrst,
	input rxia_pkg::rxia_reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	output rxia_pkg::rxia_ram_req_t ram_req,
	input wire logic ram_ack,
	input wire logic [7:0] ram_rdata,
	output logic [7:0] integ_period_end
);
	import rxia_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RXIA_ST_IDLE = 2'h0, // ready, nothing in flight
		RXIA_ST_REQ = 2'h1, // request raised, waiting for ack
		RXIA_ST_RELEASE = 2'h3 // request dropped, waiting for ack low
	} rxia_state_t;

	logic [RXIA_INTEG_STORE_W-1:0] integ_q [RXIA_NUM_INTEG_REGS]; // 11:0 kept
	logic [RXIA_INTEG_STORE_W-1:0] integ_d [RXIA_NUM_INTEG_REGS];
	logic ready_q, ready_d; // transfer finished
	logic toggle_q, toggle_d; // flips on every ready rise
	logic dir_q, dir_d; // 1 = ram to registers
	logic rsvd_q, rsvd_d; // reserved bit, stored only
	logic [1:0] mode_q, mode_d; // access selector
	logic [7:0] data_q, data_d; // byte moved per transfer
	rxia_state_t state_q, state_d;
	rxia_ram_op_t op_q, op_d; // op of the transfer in flight
	logic [15:0] rdata_q, rdata_d; // registered read data
	logic ack_s1_q, ack_s2_q; // ack synchroniser
	logic [7:0] rdat_s1_q, rdat_s2_q; // ram data synchroniser
	logic ctrl_wr, data_wr; // decoded write strobes
	logic start; // accepted new transfer

	// integration register index from address, -1 when unmapped
	function automatic int integ_index(input logic [9:0] a);
		unique case (a)
			RXIA_INTEG_0_4_OFS: integ_index = 0;
			RXIA_INTEG_1_5_OFS: integ_index = 1;
			RXIA_INTEG_2_6_OFS: integ_index = 2;
			RXIA_INTEG_3_7_OFS: integ_index = 3;
			default: integ_index = -1;
		endcase
	endfunction : integ_index

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// ram side answers from outside this clock: two flops before use
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			rdat_s1_q <= 8'h00;
			rdat_s2_q <= 8'h00;
		end else begin
			ack_s1_q <= ram_ack;
			ack_s2_q <= ack_s1_q;
			rdat_s1_q <= ram_rdata;
			rdat_s2_q <= rdat_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// integration registers
	// ----------------------------------------------------------------
	// reserved bits 7:4 are stored as written but never reach a timer
	always_comb begin
		for (int i = 0; i < RXIA_NUM_INTEG_REGS; i++) begin
			integ_d[i] = integ_q[i];
		end
		if (reg_req.wr && integ_index(reg_req.addr) >= 0) begin
			integ_d[integ_index(reg_req.addr)] = reg_req.wdata[RXIA_INTEG_STORE_W-1:0]; // [R2]
		end
	end

	// registers only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < RXIA_NUM_INTEG_REGS; i++) begin
				integ_q[i] <= RXIA_INTEG_RESET;
			end
		end else begin
			integ_q <= integ_d;
		end
	end

	// one timer per group; group n and n+4 share a register
	for (genvar g = 0; g < RXIA_NUM_GROUPS; g++) begin : g_timer
		localparam int REG_IDX = g % RXIA_NUM_INTEG_REGS;
		localparam int LSB = (g < RXIA_NUM_INTEG_REGS) ? RXIA_LO_CODE_LSB : RXIA_HI_CODE_LSB;
		rxia_integ_timer u_timer (
			.clk(clk),
			.nrst(nrst),
			.code(integ_q[REG_IDX][LSB +: 4]), // [R2]
			.period_end(integ_period_end[g])
		);
	end

	// ----------------------------------------------------------------
	// access control, data register and transfer sequencer
	// ----------------------------------------------------------------
	assign ctrl_wr = reg_req.wr && (reg_req.addr == RXIA_RAM_CTRL_OFS);
	assign data_wr = reg_req.wr && (reg_req.addr == RXIA_RAM_DATA_OFS);
	// a write while busy only updates fields; no second request is launched
	assign start = ctrl_wr && (state_q == RXIA_ST_IDLE);

	always_comb begin
		ready_d = ready_q;
		dir_d = dir_q;
		rsvd_d = rsvd_q;
		mode_d = mode_q;
		data_d = data_q;
		state_d = state_q;
		op_d = op_q;
		if (data_wr) begin
			data_d = reg_req.wdata[7:0]; // [R15]
		end
		if (ctrl_wr) begin
			ready_d = 1'b0; // [R7]
			dir_d = reg_req.wdata[RXIA_CTRL_DIR_BIT];
			rsvd_d = reg_req.wdata[RXIA_CTRL_RSVD_BIT];
			mode_d = reg_req.wdata[RXIA_CTRL_NOACC_BIT:RXIA_CTRL_OP_BIT];
		end
		unique case (state_q)
			RXIA_ST_IDLE: begin
				if (start && reg_req.wdata[RXIA_CTRL_NOACC_BIT]) begin
					// no access at all; only the ready low pulse and the toggle flip on its rise are seen
					ready_d = 1'b0; // [R10]
				end else if (start) begin
					state_d = RXIA_ST_REQ;
					if (!reg_req.wdata[RXIA_CTRL_OP_BIT]) begin
						op_d = RXIA_OP_INIT; // [R11]
					end else if (reg_req.wdata[RXIA_CTRL_DIR_BIT]) begin
						op_d = RXIA_OP_READ; // [R9] [R12]
					end else begin
						op_d = RXIA_OP_WRITE; // [R9] [R12]
					end
				end else if (!ready_q) begin
					ready_d = 1'b1; // [R7]
				end
			end
			RXIA_ST_REQ: begin
				if (ack_s2_q) begin
					state_d = RXIA_ST_RELEASE;
					if (op_q == RXIA_OP_READ) begin
						data_d = rdat_s2_q; // [R9]
					end
				end
			end
			RXIA_ST_RELEASE: begin
				if (!ack_s2_q) begin
					state_d = RXIA_ST_IDLE;
					ready_d = 1'b1; // [R7]
				end
			end
			default: begin
				state_d = RXIA_ST_IDLE;
			end
		endcase
		// toggle follows the ready rise, whatever caused it
		toggle_d = toggle_q ^ (ready_d & ~ready_q); // [R8]
	end

	// registers only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ready_q <= 1'b1; // [R14]
			toggle_q <= 1'b0; // [R14]
			dir_q <= 1'b0;
			rsvd_q <= 1'b0;
			mode_q <= 2'h0;
			data_q <= 8'h00;
			state_q <= RXIA_ST_IDLE;
			op_q <= RXIA_OP_INIT;
		end else begin
			ready_q <= ready_d;
			toggle_q <= toggle_d;
			dir_q <= dir_d;
			rsvd_q <= rsvd_d;
			mode_q <= mode_d;
			data_q <= data_d;
			state_q <= state_d;
			op_q <= op_d;
		end
	end

	// request held through the whole wait for ack
	always_comb begin
		ram_req.req = (state_q == RXIA_ST_REQ);
		ram_req.op = op_q;
		ram_req.wdata = data_q;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// one cycle latency: data held until the next read strobe
	always_comb begin
		rdata_d = rdata_q;
		if (reg_req.rd) begin
			rdata_d = 16'h0000;
			if (integ_index(reg_req.addr) >= 0) begin
				rdata_d[RXIA_INTEG_STORE_W-1:0] = integ_q[integ_index(reg_req.addr)]; // [R6]
			end else if (reg_req.addr == RXIA_RAM_CTRL_OFS) begin
				rdata_d[RXIA_CTRL_READY_BIT] = ready_q;
				rdata_d[RXIA_CTRL_TOGGLE_BIT] = toggle_q;
				rdata_d[RXIA_CTRL_DIR_BIT] = dir_q;
				rdata_d[RXIA_CTRL_RSVD_BIT] = rsvd_q;
				rdata_d[RXIA_CTRL_NOACC_BIT:RXIA_CTRL_OP_BIT] = mode_q;
			end else if (reg_req.addr == RXIA_RAM_DATA_OFS) begin
				rdata_d[7:0] = data_q; // [R15]
			end
		end
	end

	// registers only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : rxia_top

/* File: pkg/rxia_pkg.sv */
// package: register map, field layout, reset values and carriers for rx integration / ext ram
package rxia_pkg;

	// ----------------------------------------------------------------
	// register offsets (processor register port, 16-bit words)
	// ----------------------------------------------------------------
	localparam logic [9:0] RXIA_INTEG_0_4_OFS = 10'h219; // groups 0 and 4
	localparam logic [9:0] RXIA_INTEG_1_5_OFS = 10'h21a; // groups 1 and 5
	localparam logic [9:0] RXIA_INTEG_2_6_OFS = 10'h21b; // groups 2 and 6
	localparam logic [9:0] RXIA_INTEG_3_7_OFS = 10'h21c; // groups 3 and 7
	localparam logic [9:0] RXIA_RAM_CTRL_OFS = 10'h280; // ext ram access control
	localparam logic [9:0] RXIA_RAM_DATA_OFS = 10'h284; // ext ram read/write data

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int RXIA_NUM_INTEG_REGS = 4; // two groups per register
	localparam int RXIA_NUM_GROUPS = 8;
	localparam int RXIA_LO_CODE_LSB = 0; // group n code in 3:0
	localparam int RXIA_HI_CODE_LSB = 8; // group n+4 code in 11:8
	localparam int RXIA_INTEG_STORE_W = 12; // bits 11:0 stored, 15:12 read zero
	localparam logic [11:0] RXIA_INTEG_RESET = 12'hc0c;
	localparam int RXIA_CTRL_READY_BIT = 7;
	localparam int RXIA_CTRL_TOGGLE_BIT = 6;
	localparam int RXIA_CTRL_DIR_BIT = 5;
	localparam int RXIA_CTRL_RSVD_BIT = 2;
	localparam int RXIA_CTRL_NOACC_BIT = 1;
	localparam int RXIA_CTRL_OP_BIT = 0;

	// ----------------------------------------------------------------
	// integration period: 2^(base + code) cycles
	// ----------------------------------------------------------------
	localparam int RXIA_PERIOD_BASE_EXP = 8;
	localparam logic [3:0] RXIA_CODE_MAX = 4'he; // 1111 is undefined
	localparam int RXIA_PERIOD_CNT_W = 23; // holds up to 2^23 - 1; the longest period needs 2^22 - 1

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [9:0] addr; // word address
		logic wr; // one-cycle write strobe
		logic rd; // one-cycle read strobe
		logic [15:0] wdata;
	} rxia_reg_req_t;

	typedef enum logic [1:0] {
		RXIA_OP_INIT = 2'h0,
		RXIA_OP_READ = 2'h1,
		RXIA_OP_WRITE = 2'h2
	} rxia_ram_op_t;

	typedef struct packed {
		logic req; // held until ack seen
		rxia_ram_op_t op;
		logic [7:0] wdata; // byte to store on write
	} rxia_ram_req_t;

endpackage : rxia_pkg

/* File: rtl/rxia_integ_timer.sv */
// one group's integration period timer
`timescale 1ns/10ps
module rxia_integ_timer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] code,
	output logic period_end
);
	import rxia_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [RXIA_PERIOD_CNT_W-1:0] cnt_q, cnt_d; // cycles into period
	logic [3:0] act_code_q, act_code_d; // code of running period
	logic [3:0] safe_code; // clamped written code
	logic last; // final cycle of period
	logic [RXIA_PERIOD_CNT_W-1:0] len_m1; // period length minus one

	// period length minus one from code: 2^(8+k) - 1
	function automatic logic [RXIA_PERIOD_CNT_W-1:0] period_m1(input logic [3:0] k);
		logic [RXIA_PERIOD_CNT_W:0] one_hot;
		one_hot = '0;
		one_hot[RXIA_PERIOD_BASE_EXP + int'(k)] = 1'b1;
		period_m1 = RXIA_PERIOD_CNT_W'(one_hot - 1'b1);
	endfunction : period_m1

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		// undefined code 1111 clamped so the counter never overflows
		safe_code = (code > RXIA_CODE_MAX) ? RXIA_CODE_MAX : code;
		len_m1 = period_m1(act_code_q); // [R1]
		last = (cnt_q == len_m1);
		if (last) begin
			cnt_d = '0;
			act_code_d = safe_code; // [R17]
		end else begin
			cnt_d = cnt_q + 1'b1;
			act_code_d = act_code_q;
		end
	end

	// registers only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			act_code_q <= RXIA_INTEG_RESET[3:0];
		end else begin
			cnt_q <= cnt_d;
			act_code_q <= act_code_d;
		end
	end

	// pulse on the last cycle of each period
	assign period_end = last;

endmodule : rxia_integ_timer

/* File: verif/rxia_assertions.sv */
// checker: port-level properties of the rx integration / ext ram block
`timescale 1ns/10ps
module rxia_checker
	import rxia_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input rxia_pkg::rxia_reg_req_t reg_req,
	input wire logic [15:0] reg_rdata,
	input rxia_pkg::rxia_ram_req_t ram_req,
	input wire logic ram_ack,
	input wire logic [7:0] ram_rdata,
	input wire logic [7:0] integ_period_end
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// decoded strobes
	// ----------------------------------------------------------------
	logic ctrl_wr; // control word write
	logic ctrl_rd; // control word read
	logic integ_rd; // any integration word read
	assign ctrl_wr = reg_req.wr && reg_req.addr == RXIA_RAM_CTRL_OFS;
	assign ctrl_rd = reg_req.rd && reg_req.addr == RXIA_RAM_CTRL_OFS;
	assign integ_rd = reg_req.rd && reg_req.addr >= RXIA_INTEG_0_4_OFS
		&& reg_req.addr <= RXIA_INTEG_3_7_OFS;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// the first status read after a control write comes two cycles later
	a_ready_clear: assert property (ctrl_wr && !reg_req.wdata[1] ##2 ctrl_rd |=>
		!reg_rdata[7])
		else $error("ready still set after control write");
	a_no_access: assert property (ctrl_wr && reg_req.wdata[1] |=> !ram_req.req [*8])
		else $error("ram request while access blocked");
	a_init_op: assert property (ctrl_wr && reg_req.wdata[1:0] == 2'b00 |=>
		ram_req.req && ram_req.op == RXIA_OP_INIT)
		else $error("init request missing");
	a_dir_read: assert property (ctrl_wr && reg_req.wdata[1:0] == 2'b01 &&
		reg_req.wdata[5] |=> ram_req.req && ram_req.op == RXIA_OP_READ)
		else $error("read request missing");
	a_dir_write: assert property (ctrl_wr && reg_req.wdata[1:0] == 2'b01 &&
		!reg_req.wdata[5] |=> ram_req.req && ram_req.op == RXIA_OP_WRITE)
		else $error("write request missing");
	a_req_release: assert property ($rose(ram_ack) && ram_req.req |->
		ram_req.req [*3] ##1 !ram_req.req)
		else $error("request not released three cycles after ack");
	a_req_stable: assert property (ram_req.req && $past(ram_req.req) |->
		$stable(ram_req.op) && $stable(ram_req.wdata))
		else $error("request fields moved during transfer");
	a_integ_top: assert property (integ_rd |=> reg_rdata[15:12] == 4'h0)
		else $error("integration upper nibble not zero");
	a_ctrl_unused: assert property (ctrl_rd |=> reg_rdata[15:8] == 8'h00 &&
		reg_rdata[4:3] == 2'h0)
		else $error("control unused bits not zero");
	// main scenarios reached
	c_read: cover property (ram_req.req && ram_req.op == RXIA_OP_READ);
	c_ack: cover property ($rose(ram_ack));
	c_blocked: cover property (ctrl_wr && reg_req.wdata[1]);
endmodule : rxia_checker

bind rxia_top rxia_checker rxia_checker_inst (.clk(clk), .nrst(nrst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .ram_req(ram_req), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
	.integ_period_end(integ_period_end));

/* File: verif/rxia_ram_model.sv */
// partner: external ram, four-phase handshake, one byte of storage
`timescale 1ns/10ps
module rxia_ram_model
	import rxia_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input rxia_pkg::rxia_ram_req_t ram_req,
	input wire logic [7:0] wait_cycles,
	output logic ram_ack,
	output logic [7:0] ram_rdata,
	output logic [7:0] mem,
	output logic [7:0] req_count
);
	logic [7:0] cnt; // slow-answer counter
	logic req_seen; // last request level
	// ----------------------------------------------------------------
	// handshake and storage
	// ----------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ram_ack <= 1'b0;
			ram_rdata <= 8'h5a;
			mem <= 8'h3c;
			req_count <= 8'h00;
			cnt <= 8'h00;
			req_seen <= 1'b0;
		end else begin
			req_seen <= ram_req.req;
			if (ram_req.req && !req_seen) begin
				req_count <= req_count + 8'h01;
			end
			if (ram_req.req && !ram_ack) begin
				if (cnt < wait_cycles) begin
					cnt <= cnt + 8'h01;
				end else begin
					ram_ack <= 1'b1;
					cnt <= 8'h00;
					case (ram_req.op)
						RXIA_OP_INIT: mem <= 8'h00;
						RXIA_OP_READ: ram_rdata <= mem;
						RXIA_OP_WRITE: mem <= ram_req.wdata;
						default: ;
					endcase
				end
			end else if (!ram_req.req && ram_ack) begin
				// released data no longer shows the byte
				ram_ack <= 1'b0;
				ram_rdata <= ~ram_rdata;
			end
		end
	end
endmodule : rxia_ram_model

/* File: verif/test_rx_integration_and_ext_ram_access.sv */
// testbench: register port sequences against the external ram model
`timescale 1ns/10ps
module test_rx_integration_and_ext_ram_access;
	import rxia_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	rxia_reg_req_t reg_req = '0;
	logic [15:0] reg_rdata;
	rxia_ram_req_t ram_req;
	logic ram_ack;
	logic [7:0] ram_rdata;
	logic [7:0] integ_period_end;
	logic [7:0] wait_cycles = 8'h00;
	logic [7:0] mem;
	logic [7:0] req_count;
	logic [15:0] rd_val;
	logic tog = 1'b0; // expected toggle bit
	// never 1111; includes the suggested e1, t1 and t1 isdn codes
	logic [7:0] codes [4] = '{8'he0, 8'hcb, 8'h91, 8'hd7};
	int bad_count = 0;
	int checks = 0;
	int pulses = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (|integ_period_end) pulses++;
	rxia_top rxia_top_inst (.clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.ram_req(ram_req), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
		.integ_period_end(integ_period_end));
	rxia_ram_model rxia_ram_model_inst (.clk(clk), .nrst(nrst), .ram_req(ram_req),
		.wait_cycles(wait_cycles), .ram_ack(ram_ack), .ram_rdata(ram_rdata), .mem(mem),
		.req_count(req_count));
	// ----------------------------------------------------------------
	// register port tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("mismatches %0d of %0d checks", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp16
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a);
		@(posedge clk);
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge clk);
		reg_req.rd <= 1'b0;
		@(posedge clk);
		#1 rd_val = reg_rdata;
	endtask : rd
	task automatic chk(input logic [9:0] a, input logic [15:0] e);
		rd(a);
		cmp16(rd_val, e);
	endtask : chk
	// control write, poll ready under a bound, then check the whole word
	task automatic xfer(input logic [15:0] c);
		int n = 0;
		wr(RXIA_RAM_CTRL_OFS, c);
		rd(RXIA_RAM_CTRL_OFS);
		if (!c[1]) cmp16(rd_val & 16'h0080, 16'h0000);
		// a lost transfer is counted once; the rest of the run stays bounded
		while (rd_val[7] !== 1'b1) begin
			n++;
			if (n > 60) begin
				bad_count++;
				$display("[ERR] %0t ready never returned", $time);
				return;
			end
			rd(RXIA_RAM_CTRL_OFS);
		end
		tog = ~tog;
		cmp16(rd_val, {8'h00, 1'b1, tog, c[5], 2'b00, c[2:0]});
	endtask : xfer
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		chk(RXIA_RAM_CTRL_OFS, 16'h0080);
		for (int i = 0; i < 4; i++) chk(RXIA_INTEG_0_4_OFS + 10'(i), 16'h0c0c);
		for (int i = 0; i < 4; i++) begin
			wr(RXIA_INTEG_0_4_OFS + 10'(i), {4'hf, codes[i][7:4], 4'h0, codes[i][3:0]});
			chk(RXIA_INTEG_0_4_OFS + 10'(i), {4'h0, codes[i][7:4], 4'h0, codes[i][3:0]});
		end
		wr(10'h200, 16'hffff);
		chk(10'h200, 16'h0000);
		wr(RXIA_RAM_DATA_OFS, 16'h12a5);
		chk(RXIA_RAM_DATA_OFS, 16'h00a5);
		xfer(16'h0001);
		cmp16({8'h00, mem}, 16'h00a5);
		wr(RXIA_RAM_DATA_OFS, 16'h0000);
		@(posedge clk) wait_cycles <= 8'd20;
		xfer(16'h0021);
		chk(RXIA_RAM_DATA_OFS, 16'h00a5);
		xfer(16'h0000);
		cmp16({8'h00, mem}, 16'h0000);
		xfer(16'h0021);
		chk(RXIA_RAM_DATA_OFS, 16'h0000);
		xfer(16'h0003);
		cmp16({8'h00, req_count}, 16'h0004);
		// reset code gives a 2^20 cycle first period, longer than this run
		cmp16(16'(pulses), 16'h0000);
		stop_test();
	end
endmodule : test_rx_integration_and_ext_ram_access
